// *** verilog/ebrc_pkg.sv ***
// shared types and constants for the external bus ready cycle control block
// assumes a single 50 MHz system clock that also serves as the reference clock input
package ebrc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;          // system clock period
	localparam int unsigned ADDR_W        = 24;          // external address width
	localparam int unsigned DATA_W        = 16;          // external data width
	localparam int unsigned LEN_W         = 6;           // wide enough for access length 32
	localparam int unsigned CNT_W         = 5;           // remaining units minus one
	localparam int unsigned SYNC_STAGES   = 2;           // async ready synchroniser depth
	localparam logic [LEN_W-1:0] AB_LEN_MIN = 6'h01;     // address setup, least units
	localparam logic [LEN_W-1:0] E_LEN_MIN  = 6'h01;     // access phase, least units
	localparam logic [LEN_W-1:0] E_LEN_MAX  = 6'h20;     // access phase, most units
	localparam logic [LEN_W-1:0] LEN_ZERO   = 6'h00;     // a phase that is skipped

	// one-hot cycle phase codes
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_AB   = 7'h02,   // address setup
		ST_C    = 7'h04,   // command delay
		ST_D    = 7'h08,   // write data setup or tristate
		ST_E    = 7'h10,   // access, mandatory units
		ST_RDY  = 7'h20,   // ready-controlled wait units
		ST_F    = 7'h40    // address or write data hold
	} ebrc_state_t;

	// per-cycle timing and ready handling, taken with each request
	typedef struct packed {
		logic [LEN_W-1:0] ab_len;     // address setup units
		logic [LEN_W-1:0] c_len;      // command delay units
		logic [LEN_W-1:0] d_len;      // write data setup units
		logic [LEN_W-1:0] e_len;      // access_phase_length
		logic [LEN_W-1:0] f_len;      // hold units
		logic             rdy_en;     // access ended by ready handshake
		logic             rdy_pol;    // 1: ready active high, 0: active low
		logic             rdy_async;  // 1: ready passes through the synchroniser
	} ebrc_cfg_t;

	// one bus request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;      // target address
		logic [DATA_W-1:0] wdata;     // write data
		logic              write;     // 1: write, 0: read
		logic              hi_en;     // drive high byte enable
	} ebrc_req_t;
endpackage : ebrc_pkg

// *** verilog/ebrc_top.sv ***
// external bus cycle engine with ready-handshake wait states, demultiplexed pins
// assumes all inputs synchronous to REF_CLK_IN except the ready pin in async mode;
// one bus_phase_clock_unit equals one system clock
//
// Notes on behaviour
// RQ1 - five phases, each with programmed length
// RQ2 - access length optionally governed by ready
// RQ3 - read data caught on command end edge
// RQ4 - early address change never disturbs read data
// RQ5 - ready polarity is selectable
// RQ6 - synchronous ready gives the shortest cycle
// RQ7 - async ready adds a synchroniser, wait state
// RQ8 - partner holds async ready one period plus
// RQ9 - partner may drop ready after command ends
// RQ10 - partner drops ready before next sample point
// RQ11 - inactive ready inserts a wait, resample
// RQ12 - active ready ends the running cycle
// RQ13 - async sampling point later than sync
// RQ14 - ready ignored during mandatory access units
// RQ15 - two flip-flop synchroniser for async ready
`timescale 1ns/1ps
module ebrc_top
	import ebrc_pkg::*;
(
	input  wire logic              REF_CLK_IN,       // system and reference clock
	input  wire logic              RESET_N_IN,       // async reset, active low
	input  wire logic              REQ_VALID_IN,     // request offered
	input  wire ebrc_req_t         REQ_IN,           // request contents
	input  wire ebrc_cfg_t         CFG_IN,           // timing taken with the request
	output logic                   REQ_READY_OUT,    // engine idle, request taken
	output logic                   DONE_OUT,         // one-cycle pulse at cycle end
	output logic [DATA_W-1:0]      RD_DATA_OUT,      // captured read data
	output logic [ADDR_W-1:0]      ADDR_OUT,         // address pins
	output logic                   CS_N_OUT,         // chip select, active low
	output logic                   RD_N_OUT,         // read strobe, active low
	output logic                   WR_N_OUT,         // write strobe, active low
	output logic                   HIGH_BYTE_ENABLE_N_OUT, // high byte enable
	input  wire logic [DATA_W-1:0] DATA_IN,          // data pins, sensed
	output logic [DATA_W-1:0]      DATA_OUT,         // data pins, driven
	output logic                   DATA_OE_OUT,      // high while driving data
	input  wire logic              READY_IN          // ready handshake pin
);
	// state group
	ebrc_state_t        state_ff, nxt_state;   // cycle phase
	logic [CNT_W-1:0]   cnt_ff, nxt_cnt;       // units left in phase, minus one
	ebrc_cfg_t          cfg_ff, nxt_cfg;       // timing of the running cycle
	ebrc_req_t          req_ff, nxt_req;       // running request
	logic [DATA_W-1:0]  rdat_ff, nxt_rdat;     // captured read data
	logic               done_ff, nxt_done;     // end-of-cycle pulse
	// pin group
	logic               cs_n_ff, nxt_cs_n;     // chip select
	logic               rd_n_ff, nxt_rd_n;     // read strobe
	logic               wr_n_ff, nxt_wr_n;     // write strobe
	logic               oe_ff, nxt_oe;         // data drive enable
	// synchroniser group
	logic               sy1_ff, nxt_sy1;       // first stage, read only by sy2
	logic               sy2_ff, nxt_sy2;       // second stage
	// decision terms
	logic               raw_act;               // pin, polarity applied
	logic               syn_act;               // synchronised, polarity applied
	logic               sel_act;               // value at the active sampling point
	logic               end_e;                 // last mandatory access unit
	logic               finish;                // command ends at this edge

	// length of a phase as count minus one; zero-length phases never get here
	function automatic logic [CNT_W-1:0] len_of(input ebrc_state_t s, input ebrc_cfg_t c);
		logic [LEN_W-1:0] l;
		l = LEN_ZERO;
		case (s)
			ST_AB:   l = (c.ab_len < AB_LEN_MIN) ? AB_LEN_MIN : c.ab_len;
			ST_C:    l = c.c_len;
			ST_D:    l = c.d_len;
			ST_E:    l = (c.e_len < E_LEN_MIN) ? E_LEN_MIN :
				 (c.e_len > E_LEN_MAX) ? E_LEN_MAX : c.e_len;
			ST_F:    l = c.f_len;
			default: l = E_LEN_MIN;
		endcase
		len_of = CNT_W'(l - 6'h01);
	endfunction : len_of

	// first phase after s with nonzero length, in fixed phase order
	function automatic ebrc_state_t after(input ebrc_state_t s, input ebrc_cfg_t c);
		ebrc_state_t n;
		n = ST_IDLE;
		case (s)
			ST_AB:   n = (c.c_len != LEN_ZERO) ? ST_C : (c.d_len != LEN_ZERO) ? ST_D : ST_E;
			ST_C:    n = (c.d_len != LEN_ZERO) ? ST_D : ST_E;
			ST_D:    n = ST_E;
			ST_E,
			ST_RDY:  n = (c.f_len != LEN_ZERO) ? ST_F : ST_IDLE;
			default: n = ST_IDLE;
		endcase
		after = n;
	endfunction : after

	// ready terms; polarity applied after the synchroniser so the first stage
	// sees nothing but the pin
	always_comb begin
		raw_act = (READY_IN == cfg_ff.rdy_pol);                       // [RQ5]
		syn_act = (sy2_ff == cfg_ff.rdy_pol);                         // [RQ5]
		sel_act = cfg_ff.rdy_async ? syn_act : raw_act;               // [RQ13]
		end_e   = (state_ff == ST_E) && (cnt_ff == '0);
	end

	// synchroniser next values
	always_comb begin
		nxt_sy1 = READY_IN;                                           // [RQ15]
		nxt_sy2 = sy1_ff;                                             // [RQ15]
	end

	// cycle sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_cfg   = cfg_ff;
		nxt_req   = req_ff;
		nxt_rdat  = rdat_ff;
		nxt_done  = 1'b0;
		finish    = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (REQ_VALID_IN) begin
					nxt_cfg   = CFG_IN;
					nxt_req   = REQ_IN;
					nxt_state = ST_AB;
					nxt_cnt   = len_of(ST_AB, CFG_IN);              // [RQ1]
				end
			end
			ST_AB, ST_C, ST_D, ST_F: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;                        // [RQ1]
				end else begin
					nxt_state = after(state_ff, cfg_ff);            // [RQ1]
					nxt_cnt   = len_of(nxt_state, cfg_ff);
					nxt_done  = (state_ff == ST_F);
				end
			end
			ST_E: begin
				// ready is not looked at before the mandatory units run out
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;                        // [RQ14]
				end else if (!cfg_ff.rdy_en) begin
					finish = 1'b1;                                  // [RQ2]
				end else if (cfg_ff.rdy_async) begin
					nxt_state = ST_RDY;                             // [RQ7]
				end else if (raw_act) begin
					finish = 1'b1;                                  // [RQ6] [RQ12]
				end else begin
					nxt_state = ST_RDY;                             // [RQ11]
				end
			end
			ST_RDY: begin
				if (sel_act) begin
					finish = 1'b1;                                  // [RQ12]
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (finish) begin
			// read data taken on the same edge that lifts the strobe; the
			// address is never looked at, so changing it early is harmless
			if (!req_ff.write) begin
				nxt_rdat = DATA_IN;                                 // [RQ3] [RQ4]
			end
			nxt_state = after(state_ff, cfg_ff);
			nxt_cnt   = len_of(nxt_state, cfg_ff);
			nxt_done  = (nxt_state == ST_IDLE);
		end
	end

	// pin levels follow the phase being entered, so strobes change on phase edges
	always_comb begin
		nxt_cs_n = (nxt_state == ST_IDLE);
		nxt_rd_n = !(!nxt_req.write && ((nxt_state == ST_E) || (nxt_state == ST_RDY)));
		nxt_wr_n = !(nxt_req.write && ((nxt_state == ST_E) || (nxt_state == ST_RDY)));
		nxt_oe   = nxt_req.write && (nxt_state inside {ST_D, ST_E, ST_RDY, ST_F});
	end

	// registers only
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= '0;
			cfg_ff   <= '0;
			req_ff   <= '0;
			rdat_ff  <= '0;
			done_ff  <= 1'b0;
			cs_n_ff  <= 1'b1;
			rd_n_ff  <= 1'b1;
			wr_n_ff  <= 1'b1;
			oe_ff    <= 1'b0;
			sy1_ff   <= 1'b0;
			sy2_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			cfg_ff   <= nxt_cfg;
			req_ff   <= nxt_req;
			rdat_ff  <= nxt_rdat;
			done_ff  <= nxt_done;
			cs_n_ff  <= nxt_cs_n;
			rd_n_ff  <= nxt_rd_n;
			wr_n_ff  <= nxt_wr_n;
			oe_ff    <= nxt_oe;
			sy1_ff   <= nxt_sy1;
			sy2_ff   <= nxt_sy2;
		end
	end

	// outputs
	always_comb begin
		REQ_READY_OUT          = (state_ff == ST_IDLE);
		DONE_OUT               = done_ff;
		RD_DATA_OUT            = rdat_ff;
		ADDR_OUT               = req_ff.addr;
		CS_N_OUT               = cs_n_ff;
		RD_N_OUT               = rd_n_ff;
		WR_N_OUT               = wr_n_ff;
		HIGH_BYTE_ENABLE_N_OUT = cs_n_ff | !req_ff.hi_en;
		DATA_OUT               = req_ff.wdata;
		DATA_OE_OUT            = oe_ff;
	end

	// checks
	phase_order_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ1]
		(state_ff == ST_E) && ($past(state_ff) != ST_E) |->
		$past(state_ff) inside {ST_AB, ST_C, ST_D})
		else $error("access phase entered out of order");
	read_capture_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ3]
		finish && !req_ff.write |=> (rdat_ff == $past(DATA_IN)) && rd_n_ff)
		else $error("read data not caught with strobe rise");
	read_hold_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ4]
		!finish |=> $stable(rdat_ff))
		else $error("read data changed outside command end");
	sync_short_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ6]
		end_e && cfg_ff.rdy_en && !cfg_ff.rdy_async && (READY_IN == cfg_ff.rdy_pol)
		|=> state_ff != ST_RDY ##1 state_ff != ST_RDY)
		else $error("sync ready did not end the cycle at once");
	async_wait_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ7]
		end_e && cfg_ff.rdy_en && cfg_ff.rdy_async |=> state_ff == ST_RDY)
		else $error("async ready skipped its wait state");
	wait_insert_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ11]
		(state_ff == ST_RDY) && !sel_act |=> (state_ff == ST_RDY) && (!rd_n_ff || !wr_n_ff))
		else $error("inactive ready did not extend the cycle");
	ready_end_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ12]
		(state_ff == ST_RDY) && sel_act |=> rd_n_ff && wr_n_ff)
		else $error("active ready did not end the command");
	async_point_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ13]
		(state_ff == ST_RDY) && cfg_ff.rdy_async && ($past(READY_IN, 2) != cfg_ff.rdy_pol)
		|=> state_ff == ST_RDY)
		else $error("async ready sampled before synchroniser");
	mand_units_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ14]
		(state_ff == ST_E) && (cnt_ff != '0) |=> state_ff == ST_E)
		else $error("ready used during mandatory access units");
	sync_chain_a: assert property (@(posedge REF_CLK_IN) disable iff (!RESET_N_IN) // [RQ15]
		##2 sy2_ff == $past(READY_IN, 2))
		else $error("ready synchroniser is not two stages");
endmodule : ebrc_top

// *** verif/ebrc_ext_model.sv ***
// behavioural external memory that answers bus cycles with a ready handshake
// assumes demultiplexed pins, outputs changed just after each rising clock edge
`timescale 1ns/1ps
module ebrc_ext_model
	import ebrc_pkg::*;
(
	input  wire logic              clk_in,      // reference clock
	input  wire logic              rst_n_in,    // async reset, active low
	input  wire logic              cs_n_in,     // chip select
	input  wire logic              rd_n_in,     // read strobe
	input  wire logic              wr_n_in,     // write strobe
	input  wire logic              be_n_in,     // high byte enable
	input  wire logic              oe_in,       // device drives data
	input  wire logic [DATA_W-1:0] wdata_in,    // data from the device
	input  wire logic [3:0]        dly_in,      // edges until ready, 0 never
	input  wire logic              pol_in,      // active ready level
	input  wire logic [DATA_W-1:0] rword_in,    // word returned on reads
	output logic [DATA_W-1:0]      rdata_out,   // data toward the device
	output logic                   ready_out,   // ready pin
	output logic [DATA_W+1:0]      wr_seen_out  // {oe, be_n, data} seen in a write
);
	logic [3:0] cnt_ff;   // edges seen with the command low
	logic       rdy_ff;   // ready asserted
	// count the command, raise ready after the requested delay
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff      <= 4'h0;
			rdy_ff      <= 1'b0;
			wr_seen_out <= '0;
		end else if (!cs_n_in && (!rd_n_in || !wr_n_in)) begin
			cnt_ff <= cnt_ff + 4'h1;
			// once up, ready stays until the command ends or the 4-bit edge count wraps
			rdy_ff <= (dly_in != 4'h0) && ((cnt_ff + 4'h1) >= dly_in);
			if (!wr_n_in) begin
				wr_seen_out <= {oe_in, be_n_in, wdata_in};
			end
		end else begin
			// drop ready once the command rises, long before next sample
			cnt_ff <= 4'h0;
			rdy_ff <= 1'b0;
		end
	end
	// ready driven synchronously to the reference clock
	assign ready_out = rdy_ff ? pol_in : ~pol_in;
	// bus released outside reads: inverse data so a late capture shows up
	assign rdata_out = (!cs_n_in && !rd_n_in) ? rword_in : ~rword_in;
endmodule : ebrc_ext_model

// *** verif/test_ebrc_top.sv ***
// self-checking bench for the ready-controlled bus cycle engine
// assumes one 50 MHz clock; inputs move on the falling edge
`timescale 1ns/1ps
module test_ebrc_top;
	import ebrc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, pol = 1'b1;
	logic [3:0] dly = 4'h0;
	logic [DATA_W-1:0] rword = 16'h0000;
	ebrc_req_t req = '0;
	ebrc_cfg_t cfg = '0;
	logic rdy_o, done, cs_n, rd_n, wr_n, be_n, oe, ready;
	logic [DATA_W-1:0] rd_data, din, dout;
	logic [DATA_W+1:0] wr_seen;
	logic [ADDR_W-1:0] addr;      // address pins
	logic [1:0]        busy;      // {request ready, chip select} just after the taking edge
	int error_cnt = 0, samples_checked = 0, n;
	initial forever #10 clk = ~clk;
	ebrc_top dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(valid), .REQ_IN(req),
		.CFG_IN(cfg), .REQ_READY_OUT(rdy_o), .DONE_OUT(done), .RD_DATA_OUT(rd_data),
		.ADDR_OUT(addr), .CS_N_OUT(cs_n), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n),
		.HIGH_BYTE_ENABLE_N_OUT(be_n), .DATA_IN(din), .DATA_OUT(dout),
		.DATA_OE_OUT(oe), .READY_IN(ready));
	ebrc_ext_model mem (.clk_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .be_n_in(be_n), .oe_in(oe), .wdata_in(dout), .dly_in(dly),
		.pol_in(pol), .rword_in(rword), .rdata_out(din), .ready_out(ready),
		.wr_seen_out(wr_seen));
	task automatic print_verdict;
		$display("errors %0d, comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// cycle counts from the taking edge to the done pulse
	task automatic cmp_cnt(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_cnt
	// data values seen at the pins or the read port
	task automatic cmp_data(input logic [DATA_W+1:0] got, input logic [DATA_W+1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_data
	// cfg word from lengths and ready controls
	function automatic ebrc_cfg_t mk(input logic [5:0] ab, c, d, e, f, input logic en, pl, as);
		mk = {ab, c, d, e, f, en, pl, as};
	endfunction : mk
	// one bus cycle; n = edges from taking edge to the done pulse
	task automatic run(input ebrc_cfg_t c, input logic wr, input logic [3:0] dl,
		input logic [DATA_W-1:0] w);
		n = 0;
		@(negedge clk);
		while (rdy_o !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		cfg = c;
		dly = dl;
		pol = c.rdy_pol;
		rword = w;
		req = {8'h00, 16'h4A10, ~w, wr, 1'b1};
		valid = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		// engine must be busy and selecting from the first unit on
		busy = {rdy_o, cs_n};
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			n++;
			@(negedge clk);
		end
	endtask : run
	// plain read without ready: programmed lengths only, late data flip ignored
	task automatic t_plain_read;
		run(mk(6'h01, 6'h00, 6'h00, 6'h01, 6'h01, 1'b0, 1'b1, 1'b0), 1'b0, 4'h0, 16'h3C5A);
		cmp_cnt(n, 3);
		cmp_data({2'b00, rd_data}, {2'b00, 16'h3C5A});
		cmp_data({16'h0000, busy}, 18'h0_0000);
		cmp_data({16'h0000, rdy_o, cs_n}, {16'h0000, 2'b11});
		cmp_data(addr[17:0], 18'h0_4A10);
	endtask : t_plain_read
	// every phase used, with lengths 2, 3, 1, 4 and 3, a write
	task automatic t_long_write;
		run(mk(6'h02, 6'h03, 6'h01, 6'h04, 6'h03, 1'b0, 1'b1, 1'b0), 1'b1, 4'h0, 16'h481E);
		cmp_cnt(n, 13);
		cmp_data(wr_seen, {1'b1, 1'b0, 16'hB7E1});
	endtask : t_long_write
	// sync ready, both polarities, one wait per edge of partner delay
	task automatic t_sync_ready;
		for (int p = 0; p < 2; p++) begin
			for (int d = 1; d < 4; d++) begin
				run(mk(6'h01, 6'h00, 6'h00, 6'h01, 6'h01, 1'b1, p[0], 1'b0), 1'b0, d[3:0],
					16'h1E00 + 16'(d));
				cmp_cnt(n, 3 + d);
				cmp_data({2'b00, rd_data}, {2'b00, 16'h1E00 + 16'(d)});
			end
		end
	endtask : t_sync_ready
	// ready already up during mandatory access units must not cut them short
	task automatic t_mandatory;
		run(mk(6'h01, 6'h00, 6'h00, 6'h03, 6'h01, 1'b1, 1'b1, 1'b0), 1'b0, 4'h1, 16'h7710);
		cmp_cnt(n, 5);
	endtask : t_mandatory
	// async ready costs at least one wait more than sync with the same partner
	task automatic t_async;
		for (int p = 0; p < 2; p++) begin
			run(mk(6'h01, 6'h00, 6'h00, 6'h01, 6'h01, 1'b1, p[0], 1'b1), 1'b0, 4'h1, 16'h2B2B);
			cmp_cnt((n >= 6 && n <= 7) ? 1 : 0, 1);
		end
	endtask : t_async
	// main sequence: reset two cycles, then scenarios
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_plain_read();
		t_long_write();
		t_sync_ready();
		t_mandatory();
		t_async();
		print_verdict();
	end
	// watchdog: scenarios need well under 400 cycles
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule : test_ebrc_top
